// file: rtl/dsp_seq.sv
`timescale 1ns/1ps
module dsp_seq
#(
  parameter int T_INT_CYC = dsp_pkg::T_INT_CYC,
  parameter int CNT_W     = dsp_pkg::CNT_W
)
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset,
  // User request and channel choice.
  input  wire logic             start,
  input  wire logic [1:0]       chan,
  // Result.
  output logic                  busy,
  output logic                  done,
  output logic                  sign,
  output logic [CNT_W-1:0]      magnitude,
  // Converter pins.
  output logic [1:0]            ph_code,
  output logic                  mux_sel_hi,
  output logic                  mux_sel_lo,
  input  wire logic             zero_cross_out
);
  // Phase lengths and the sign sampling point, all at the counter width.
  localparam logic [CNT_W-1:0] TINT      = CNT_W'(T_INT_CYC);
  localparam logic [CNT_W-1:0] SLEAD     = CNT_W'(dsp_pkg::SIGN_LEAD_CYC);
  localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);
  localparam logic [CNT_W-1:0] TINT_LAST = TINT - ONE;
  localparam logic [CNT_W-1:0] SIGN_AT   = TINT - SLEAD;
  localparam logic [CNT_W-1:0] CNT_MAX   = '1;

  // Synchronised comparator view.
  dsp_sync_if zc ();
  logic                zc_level;
  logic                zc_rise;
  logic                zc_fall;

  // Sequencer state.
  dsp_pkg::dsp_state_t state_ff;
  dsp_pkg::dsp_state_t nxt_state;
  logic [CNT_W-1:0]    cnt_ff;
  logic [CNT_W-1:0]    nxt_cnt;
  logic [1:0]          ph_ff;
  logic [1:0]          nxt_ph;

  // Result state.
  logic                busy_ff;
  logic                nxt_busy;
  logic                done_ff;
  logic                nxt_done;
  logic                sign_ff;
  logic                nxt_sign;
  logic [CNT_W-1:0]    mag_ff;
  logic [CNT_W-1:0]    nxt_mag;
  logic [1:0]          chan_ff;
  logic [1:0]          nxt_chan;

  // The comparator is asynchronous, so it passes two stages before any use.
  dsp_sync u_sync
  (
    .clk    (clk),
    .reset  (reset),
    .pin_in (zero_cross_out),
    .so     (zc)
  );

  // Local copies keep the interface out of the state logic.
  assign zc_level = zc.level;
  assign zc_rise  = zc.rise;
  assign zc_fall  = zc.fall;

  // Next phase, count and state of the conversion sequence.
  // The phase code is registered together with the state, so pins and state never disagree.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_ph    = ph_ff;
    case (state_ff)
      dsp_pkg::ST_IDLE:
      begin
        // Auto-zero doubles as the idle phase and may last any time.
        nxt_ph = dsp_pkg::PH_NULL;
        if (start)
        begin
          nxt_state = dsp_pkg::ST_NULL;
          nxt_cnt   = '0;
        end
      end
      dsp_pkg::ST_NULL:
      begin
        nxt_ph = dsp_pkg::PH_NULL;
        // Auto-zero before integrating lasts as long as integration itself.
        if (cnt_ff == TINT_LAST)
        begin
          nxt_state = dsp_pkg::ST_INTEG;
          nxt_cnt   = '0;
          nxt_ph    = dsp_pkg::PH_INTEG;
        end
        else
        begin
          nxt_cnt = cnt_ff + ONE;
        end
      end
      dsp_pkg::ST_INTEG:
      begin
        // The same fixed length every time; the code then steps straight to 11.
        if (cnt_ff == TINT_LAST)
        begin
          nxt_state = dsp_pkg::ST_RAMP;
          nxt_cnt   = '0;
          nxt_ph    = dsp_pkg::PH_RAMP;
        end
        else
        begin
          nxt_cnt = cnt_ff + ONE;
        end
      end
      dsp_pkg::ST_RAMP:
      begin
        // The count runs from the code change to the comparator fall.
        if (zc_fall)
        begin
          nxt_state = dsp_pkg::ST_CLEAR;
          nxt_ph    = dsp_pkg::PH_CLEAR;
        end
        else if (cnt_ff != CNT_MAX)
        begin
          // Saturates rather than wraps; a dead comparator leaves the block busy.
          nxt_cnt = cnt_ff + ONE;
        end
      end
      dsp_pkg::ST_CLEAR:
      begin
        // Leave residue clearing on the very rising edge to avoid overshoot.
        if (zc_rise)
        begin
          nxt_state = dsp_pkg::ST_IDLE;
          nxt_ph    = dsp_pkg::PH_NULL;
        end
      end
      default:
      begin
        nxt_state = dsp_pkg::ST_IDLE;
        nxt_ph    = dsp_pkg::PH_NULL;
      end
    endcase
  end

  // Registers the sequencer.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= dsp_pkg::ST_IDLE;
      cnt_ff   <= '0;
      ph_ff    <= dsp_pkg::PH_NULL;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ph_ff    <= nxt_ph;
    end
  end

  // Next values of the result and the channel choice.
  always_comb
  begin
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_sign = sign_ff;
    nxt_mag  = mag_ff;
    nxt_chan = chan_ff;
    if ((state_ff == dsp_pkg::ST_IDLE) && start)
    begin
      // The channel is latched at start so it is settled before integration.
      nxt_busy = 1'b1;
      nxt_chan = chan;
    end
    // Early samples are noisy, so the sign is taken just before integration ends.
    if ((state_ff == dsp_pkg::ST_INTEG) && (cnt_ff == SIGN_AT))
    begin
      nxt_sign = zc_level;
    end
    if ((state_ff == dsp_pkg::ST_RAMP) && zc_fall)
    begin
      nxt_mag = cnt_ff;
    end
    if ((state_ff == dsp_pkg::ST_CLEAR) && zc_rise)
    begin
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
    end
  end

  // Registers the result.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      sign_ff <= 1'b0;
      mag_ff  <= '0;
      chan_ff <= 2'h0;
    end
    else
    begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      sign_ff <= nxt_sign;
      mag_ff  <= nxt_mag;
      chan_ff <= nxt_chan;
    end
  end

  // Every output comes straight from a register.
  assign ph_code    = ph_ff;
  assign mux_sel_hi = chan_ff[1];
  assign mux_sel_lo = chan_ff[0];
  assign busy       = busy_ff;
  assign done       = done_ff;
  assign sign       = sign_ff;
  assign magnitude  = mag_ff;

  // Steps of the conversion that the checks below are built from.
  sequence s_ramp_fall;
    (state_ff == dsp_pkg::ST_RAMP) && zc_fall;
  endsequence

  sequence s_clear_rise;
    (state_ff == dsp_pkg::ST_CLEAR) && zc_rise;
  endsequence

  sequence s_integ_sample;
    (state_ff == dsp_pkg::ST_INTEG) && (cnt_ff == SIGN_AT);
  endsequence

  // Auto-zero before integration lasts one full integration time.
  AST_NULL_LEN : assert property
    (@(posedge clk) disable iff (reset)
      ((state_ff == dsp_pkg::ST_INTEG) && ($past(state_ff) == dsp_pkg::ST_NULL)) |-> ($past(cnt_ff) == TINT_LAST))
    else $error("Auto-zero phase length differs from integration time.");

  // Integration has the same length in every conversion.
  AST_INTEG_LEN : assert property
    (@(posedge clk) disable iff (reset)
      ((state_ff == dsp_pkg::ST_RAMP) && ($past(state_ff) == dsp_pkg::ST_INTEG)) |-> ($past(cnt_ff) == TINT_LAST))
    else $error("Integration phase length is wrong.");

  // Integration is always left by stepping the code from 10 to 11.
  AST_PH_ORDER : assert property
    (@(posedge clk) disable iff (reset)
      (($past(ph_ff) == dsp_pkg::PH_INTEG) && (ph_ff != dsp_pkg::PH_INTEG)) |-> (ph_ff == dsp_pkg::PH_RAMP))
    else $error("Integration was not followed by the reference ramp.");

  // The sign is the comparator level seen at the late sampling point.
  AST_SIGN_SAMPLE : assert property
    (@(posedge clk) disable iff (reset)
      s_integ_sample |=> (sign_ff == $past(zc_level)))
    else $error("Sign was not taken from the late comparator sample.");

  // The comparator fall ends the ramp and starts residue clearing.
  AST_RAMP_STOP : assert property
    (@(posedge clk) disable iff (reset)
      s_ramp_fall |=> ((ph_ff == dsp_pkg::PH_CLEAR) && (mag_ff == $past(cnt_ff))))
    else $error("Ramp did not end on the comparator fall.");

  // Residue clearing holds until the comparator rises.
  AST_CLEAR_HOLD : assert property
    (@(posedge clk) disable iff (reset)
      ((state_ff == dsp_pkg::ST_CLEAR) && !zc_rise) |=> (ph_ff == dsp_pkg::PH_CLEAR))
    else $error("Residue clearing left before the comparator rose.");

  // The rising comparator ends clearing at once and returns to auto-zero.
  AST_CLEAR_STOP : assert property
    (@(posedge clk) disable iff (reset)
      s_clear_rise |=> ((ph_ff == dsp_pkg::PH_NULL) && done_ff))
    else $error("Residue clearing did not end on the comparator rise.");

  // Idle always shows the auto-zero code.
  AST_IDLE_NULL : assert property
    (@(posedge clk) disable iff (reset)
      (state_ff == dsp_pkg::ST_IDLE) |-> ((ph_ff == dsp_pkg::PH_NULL) && !busy_ff))
    else $error("Idle state does not hold the auto-zero code.");

  // Done is a single-cycle pulse.
  AST_DONE_PULSE : assert property
    (@(posedge clk) disable iff (reset)
      done_ff |=> !done_ff)
    else $error("Done pulse lasted more than one cycle.");
endmodule

// file: rtl/dsp_pkg.sv
package dsp_pkg;
  // Phase codes, high bit first.
  localparam logic [1:0] PH_NULL   = 2'h1;
  localparam logic [1:0] PH_INTEG  = 2'h2;
  localparam logic [1:0] PH_RAMP   = 2'h3;
  localparam logic [1:0] PH_CLEAR  = 2'h0;
  // Default phase timing in cycles of the 200 MHz clock.
  localparam int          CLK_MHZ        = 200;
  localparam int          T_INT_MS       = 66;
  localparam int          T_INT_CYC      = T_INT_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W          = 32;
  localparam int          SIGN_LEAD_CYC  = 1;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_NULL  = 3'b001,
    ST_INTEG = 3'b010,
    ST_RAMP  = 3'b011,
    ST_CLEAR = 3'b100
  } dsp_state_t;
endpackage

// file: rtl/dsp_sync_if.sv
`timescale 1ns/1ps
// Carries the synchronised comparator and its edges.
interface dsp_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// file: rtl/dsp_sync.sv
`timescale 1ns/1ps
module dsp_sync
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Raw comparator pin.
  input  wire logic pin_in,
  // Synchronised view.
  dsp_sync_if.src   so
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  // The first stage feeds only the second; edges are taken from stage two on.
  always_comb
  begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // Registers the two stages and the edge history.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // Edge pulses last one cycle each.
  assign so.level = sync_ff;
  assign so.rise  = sync_ff & ~last_ff;
  assign so.fall  = ~sync_ff & last_ff;
endmodule

// file: bench/dsp_adc_model.sv
`timescale 1ns/1ps
module dsp_adc_model
#(
  parameter int RAMP_HI  = 7,
  parameter int CLEAR_LO = 3
)
(
  // Pins.
  input  wire logic       clk,
  input  wire logic [1:0] ph_code,
  input  wire logic       pos,
  output logic            zero_cross_out
);
  logic [1:0] pc = 2'h1;
  int         n  = 0;
  initial zero_cross_out = 1'b0;
  // Counts cycles since the code last changed; toggling in auto-zero keeps the bench off a stale level.
  always @(posedge clk)
  begin
    n = (ph_code == pc) ? n + 1 : 0;
    pc <= ph_code;
    case (ph_code)
      2'h2: zero_cross_out <= pos;
      2'h3: zero_cross_out <= (n < RAMP_HI);
      2'h0: zero_cross_out <= (n > CLEAR_LO);
      default: zero_cross_out <= ~zero_cross_out;
    endcase
  end
endmodule

// file: bench/dual_slope_phase_sequencer_tb.sv
`timescale 1ns/1ps
module dual_slope_phase_sequencer_tb;
  localparam int RAMP_CYC = 7;
  logic clk = 0, reset = 1, start = 0, pos = 0, busy, done, sign, hi, lo, zc;
  logic [1:0] chan = 2'h0, ph;
  logic [31:0] mag;
  logic [2:0] q[$];
  int failures = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  dsp_seq #(.T_INT_CYC(50)) DUT (.clk(clk), .reset(reset), .start(start), .chan(chan), .busy(busy),
    .done(done), .sign(sign), .magnitude(mag), .ph_code(ph), .mux_sel_hi(hi), .mux_sel_lo(lo), .zero_cross_out(zc));
  dsp_adc_model #(.RAMP_HI(RAMP_CYC)) M (.clk(clk), .ph_code(ph), .pos(pos), .zero_cross_out(zc));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("failures=%0d checks=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Each result is matched to the oldest noted sign and channel.
  // The ramp count is the model's high time plus its one-cycle lag in seeing the code and two synchroniser stages.
  always @(posedge clk)
    if (done === 1'b1)
    begin
      chk({29'h0, sign, hi, lo}, {29'h0, q.pop_front()});
      chk(mag, 32'(RAMP_CYC + 3));
      chk({30'h0, ph}, 32'h1);
    end
  // Random channel and polarity per conversion.
  initial
  begin
    void'($urandom(32'h1288));
    repeat (6) @(negedge clk);
    reset = 0;
    repeat (6)
    begin
      @(negedge clk);
      chan = 2'($urandom);
      pos = 1'($urandom);
      start = 1;
      q.push_back({pos, chan});
      @(negedge clk);
      start = 0;
      wait (busy === 1'b0);
      repeat (3) @(negedge clk);
    end
    finish_test();
  end
  // Conversions need about 4 us; the watchdog allows five times that.
  initial
  begin
    #20000;
    failures++;
    finish_test();
  end
endmodule
